//--- hdl/esv_host.sv
/*
  Host controller for erase suspend/resume, erase-verify and continuity
  check of a parallel NOR flash. Software orders operations over a
  classic Wishbone slave; the flash is driven through its async pins.
  Assumes x16 mode, one flash, DQ sampled through two flip-flops.
*/
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Host tells erasing from suspended via polling or toggle bits; this host marks itself suspended when the suspend write ends, without polling.
// - Host writes resume to continue; extra resumes ignored by device.
// - Host keeps minimum resume-to-suspend interval before next suspend.
// - Erase-verify starts by writing 35 to the sector address.
// - Host never starts erase-verify while busy or suspended.
// - Host re-erases sector when verify reports not erased; this host has no erase operation.
// - Clear, status read expect 0, patterns, status read expect 1.
// - Resume is a single write of 30 to any address.
module esv_host
  import esv_pkg::*;
(
  input  wire logic               CLK_SYS,
  input  wire logic               RESETN,
  input  wire logic [3:0]         WB_ADR_I,
  input  wire logic [31:0]        WB_DAT_I,
  input  wire logic               WB_WE_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  output logic [31:0]             WB_DAT_O,
  output logic                    WB_ACK_O,
  output logic [esv_pkg::AW-1:0]  FL_ADDR,
  output logic [esv_pkg::DW-1:0]  FL_DQ_O,
  output logic                    FL_DQ_OE,
  input  wire logic [esv_pkg::DW-1:0] FL_DQ_I,
  output logic                    FL_CE_N,
  output logic                    FL_OE_N,
  output logic                    FL_WE_N,
  output logic                    FL_RESET_N
);
  import esv_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_SAMPLE
  } esv_state_type;
  // Step list entry: address, data, is-read
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic          rd;
  } esv_step_type;
  esv_state_type     state_ff;
  esv_op_type        op_ff;
  logic [2:0]        step_ff;
  logic [CW-1:0]     cnt_ff;
  logic [CW-1:0]     guard_ff;
  logic [AW-1:0]     addr_reg_ff;
  logic [DW-1:0]     rdata_ff;
  logic [DW-1:0]     dq_meta_ff;
  logic [DW-1:0]     dq_sync_ff;
  logic              busy_ff;
  logic              refused_ff;
  logic              suspended_ff;
  logic              cont_fail_ff;
  logic              cont_zero_ok_ff;
  logic              ack_ff;
  logic [31:0]       dat_o_ff;
  esv_flash_out_type pin_ff;
  esv_step_type      step_now;
  logic [2:0]        last_step;
  logic              wb_req;
  logic              start_ok;
  logic              fl_rst_n_ff;
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_ff;
  // Step table per operation
  always_comb begin
    step_now  = '{addr: ADDR_UNLOCK, data: CMD_SR_READ, rd: 1'b0};
    last_step = 3'h0;
    unique case (op_ff)
      OP_SUSPEND: step_now.data = CMD_SUSPEND;
      OP_RESUME:  step_now.data = CMD_RESUME;
      OP_VERIFY: begin
        step_now.addr = addr_reg_ff;
        step_now.data = CMD_VERIFY;
      end
      OP_SR_READ: begin
        last_step = 3'h1;
        if (step_ff == 3'h1) step_now.rd = 1'b1;
      end
      OP_READ: begin
        step_now.addr = addr_reg_ff;
        step_now.rd   = 1'b1;
      end
      OP_CONT: begin
        last_step = 3'h6;
        unique case (step_ff)
          3'h0: step_now.data = CMD_SR_CLEAR;
          3'h1, 3'h5: step_now.data = CMD_SR_READ;
          3'h2, 3'h6: step_now.rd = 1'b1;
          3'h3: begin
            step_now.addr = ADDR_FIRST_W;
            step_now.data = PAT_FIRST_W;
          end
          default: begin
            step_now.addr = ADDR_SECOND_W;
            step_now.data = PAT_SECOND_W;
          end
        endcase
      end
      default: ;
    endcase
  end
  // Refuse suspend too soon after resume and verify while suspended
  always_comb begin
    start_ok = 1'b1;
    if (WB_DAT_I[2:0] == 3'(OP_SUSPEND) && guard_ff != '0)
      start_ok = 1'b0;
    if (WB_DAT_I[2:0] == 3'(OP_VERIFY) && suspended_ff)
      start_ok = 1'b0;
  end
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      dq_meta_ff  <= '0;
      dq_sync_ff  <= '0;
      fl_rst_n_ff <= 1'b0;
    end else begin
      dq_meta_ff  <= FL_DQ_I;
      dq_sync_ff  <= dq_meta_ff;
      fl_rst_n_ff <= 1'b1;
    end
  end
  // Wishbone slave, answers one cycle after the request
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ack_ff   <= 1'b0;
      dat_o_ff <= '0;
    end else begin
      ack_ff   <= wb_req;
      dat_o_ff <= '0;
      if (wb_req && !WB_WE_I) begin
        unique case (WB_ADR_I)
          REG_ADDR:   dat_o_ff <= 32'(addr_reg_ff);
          REG_STATUS: dat_o_ff <= {27'h0, cont_zero_ok_ff, cont_fail_ff,
                                   suspended_ff, refused_ff, busy_ff};
          REG_RDATA:  dat_o_ff <= 32'(rdata_ff);
          default:    dat_o_ff <= '0;
        endcase
      end
    end
  end
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      addr_reg_ff <= '0;
    end else if (wb_req && WB_WE_I && WB_ADR_I == REG_ADDR && !busy_ff) begin
      addr_reg_ff <= WB_DAT_I[AW-1:0];
    end
  end
  // Suspend state tracking and resume-to-suspend guard
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      suspended_ff <= 1'b0;
      guard_ff     <= '0;
    end else begin
      if (guard_ff != '0) guard_ff <= guard_ff - 1'b1;
      if (state_ff == ST_GAP && step_ff == last_step) begin
        if (op_ff == OP_SUSPEND) suspended_ff <= 1'b1;
        if (op_ff == OP_RESUME) begin
          suspended_ff <= 1'b0;
          guard_ff     <= CW'(RES_SUS_CYC);
        end
      end
    end
  end
  // Sequencer for flash bus cycles
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_ff        <= ST_IDLE;
      op_ff           <= OP_READ;
      step_ff         <= '0;
      cnt_ff          <= '0;
      busy_ff         <= 1'b0;
      refused_ff      <= 1'b0;
      rdata_ff        <= '0;
      cont_fail_ff    <= 1'b0;
      cont_zero_ok_ff <= 1'b0;
      pin_ff          <= '{addr: '0, data: '0, we_n: 1'b1, oe_n: 1'b1,
                           ce_n: 1'b1, dq_oe: 1'b0};
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (wb_req && WB_WE_I && WB_ADR_I == REG_CTRL && WB_SEL_I[0]) begin
            refused_ff <= !start_ok;
            if (start_ok) begin
              op_ff    <= esv_op_type'(WB_DAT_I[2:0]);
              step_ff  <= '0;
              busy_ff  <= 1'b1;
              state_ff <= ST_SETUP;
              if (WB_DAT_I[2:0] == 3'(OP_CONT)) begin
                cont_fail_ff    <= 1'b0;
                cont_zero_ok_ff <= 1'b0;
              end
            end
          end
        end
        ST_SETUP: begin
          pin_ff.addr  <= step_now.addr;
          pin_ff.data  <= step_now.data;
          pin_ff.dq_oe <= !step_now.rd;
          pin_ff.ce_n  <= 1'b0;
          cnt_ff       <= CW'(step_now.rd ? ACC_CYC + 2 : WE_CYC);
          state_ff     <= ST_STROBE;
        end
        ST_STROBE: begin
          pin_ff.oe_n <= !step_now.rd;
          pin_ff.we_n <= step_now.rd;
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            state_ff <= step_now.rd ? ST_SAMPLE : ST_GAP;
          end
        end
        ST_SAMPLE: begin
          rdata_ff <= dq_sync_ff;
          if (op_ff == OP_CONT && step_ff == 3'h2 &&
              dq_sync_ff[SR_CONT_BIT]) cont_fail_ff <= 1'b1;
          if (op_ff == OP_CONT && step_ff == 3'h6) begin
            if (!dq_sync_ff[SR_CONT_BIT]) cont_fail_ff <= 1'b1;
            else cont_zero_ok_ff <= !cont_fail_ff;
          end
          state_ff <= ST_GAP;
        end
        ST_GAP: begin
          pin_ff.we_n  <= 1'b1;
          pin_ff.oe_n  <= 1'b1;
          pin_ff.ce_n  <= 1'b1;
          pin_ff.dq_oe <= 1'b0;
          if (step_ff == last_step) begin
            busy_ff  <= 1'b0;
            state_ff <= ST_IDLE;
          end else begin
            step_ff  <= step_ff + 1'b1;
            state_ff <= ST_SETUP;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  assign WB_ACK_O   = ack_ff;
  assign WB_DAT_O   = dat_o_ff;
  assign FL_ADDR    = pin_ff.addr;
  assign FL_DQ_O    = pin_ff.data;
  assign FL_DQ_OE   = pin_ff.dq_oe;
  assign FL_CE_N    = pin_ff.ce_n;
  assign FL_OE_N    = pin_ff.oe_n;
  assign FL_WE_N    = pin_ff.we_n;
  assign FL_RESET_N = fl_rst_n_ff;
  a_suspend_guard: assert property (
    $rose(busy_ff) && op_ff == OP_SUSPEND |-> $past(guard_ff) == '0)
    else $error("suspend inside guard");
  a_verify_refused: assert property (
    $rose(busy_ff) && op_ff == OP_VERIFY |-> !$past(suspended_ff))
    else $error("verify while suspended");
  a_write_strobe: assert property (
    $fell(FL_WE_N) |-> !FL_CE_N && FL_DQ_OE && FL_OE_N)
    else $error("write strobe without drive");
  a_resume_data: assert property (
    !FL_WE_N && op_ff == OP_RESUME |-> FL_DQ_O == CMD_RESUME)
    else $error("resume code wrong");
  a_pattern_one: assert property (
    !FL_WE_N && op_ff == OP_CONT && step_ff == 3'h3
    |-> FL_ADDR == ADDR_FIRST_W && FL_DQ_O == PAT_FIRST_W)
    else $error("first pattern wrong");
  a_verify_addr: assert property (
    !FL_WE_N && op_ff == OP_VERIFY
    |-> FL_ADDR == addr_reg_ff && FL_DQ_O == CMD_VERIFY)
    else $error("verify write wrong");
  a_guard_load: assert property (
    $fell(suspended_ff) |-> guard_ff == CW'(RES_SUS_CYC))
    else $error("guard not loaded");
  a_status_read: assert property (
    $fell(FL_OE_N) && op_ff == OP_CONT |-> step_ff == 3'h2 || step_ff == 3'h6)
    else $error("continuity read misplaced");
endmodule
`default_nettype wire

//--- hdl/esv_pkg.sv
/*
  Package for the flash command host: command codes, pattern words,
  address constants, timing counts, Wishbone register map and carriers.
  Assumes a 10 MHz system clock and a parallel NOR flash in x16 mode.
*/
package esv_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int AW     = 22;
  localparam int DW     = 16;

  localparam logic [DW-1:0] CMD_SUSPEND   = 16'h00b0;
  localparam logic [DW-1:0] CMD_RESUME    = 16'h0030;
  localparam logic [DW-1:0] CMD_VERIFY    = 16'h0035;
  localparam logic [DW-1:0] CMD_SR_READ   = 16'h0070;
  localparam logic [DW-1:0] CMD_SR_CLEAR  = 16'h0071;
  localparam logic [DW-1:0] PAT_FIRST_W   = 16'hff00;
  localparam logic [DW-1:0] PAT_SECOND_W  = 16'h00ff;
  localparam logic [AW-1:0] ADDR_FIRST_W  = 22'h2aaa55;
  localparam logic [AW-1:0] ADDR_SECOND_W = 22'h1555aa;
  localparam logic [AW-1:0] ADDR_UNLOCK   = 22'h000555;

  localparam int SR_READY_BIT  = 7;
  localparam int SR_VERIFY_BIT = 5;
  localparam int SR_CONT_BIT   = 0;

  // Bus cycle timing: 70 ns access rounds up to one 100 ns cycle, plus one: 2 cycles
  localparam int T_ACCESS_NS = 70;
  localparam int T_WE_NS     = 70;
  localparam int ACC_CYC = (T_ACCESS_NS * CLK_HZ / 1000 + 999_999)
                           / 1_000_000 + 1;
  localparam int WE_CYC  = (T_WE_NS * CLK_HZ / 1000 + 999_999)
                           / 1_000_000 + 1;
  // Resume-to-suspend guard, microseconds
  localparam int T_RES_SUS_US = 100;
  localparam int RES_SUS_CYC  = T_RES_SUS_US * (CLK_HZ / 1_000_000);
  localparam int CW = 16;

  // Wishbone register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RDATA  = 4'hc;

  typedef enum logic [2:0] {
    OP_SUSPEND, OP_RESUME, OP_VERIFY, OP_CONT, OP_SR_READ, OP_READ
  } esv_op_type;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic          we_n;
    logic          oe_n;
    logic          ce_n;
    logic          dq_oe;
  } esv_flash_out_type;
endpackage

//--- bench/esv_flash_model.sv
/*
  Behavioural x16 flash: command decode, status word, erase suspend,
  erase-verify timing and the continuity comparator.
  Assumes the bench merges host and model drive onto one data bus.
*/
`timescale 1ns/1ps
`default_nettype none
module esv_flash_model
  import esv_pkg::*;
#(
  parameter int         VERIFY_NS = 5000,
  parameter logic [6:0] ERASE_SEC = 7'h01
) (
  input  wire logic [esv_pkg::AW-1:0] addr,
  input  wire logic [esv_pkg::DW-1:0] dq_in,
  input  wire logic                   ce_n,
  input  wire logic                   oe_n,
  input  wire logic                   we_n,
  input  wire logic                   reset_n,
  input  wire logic                   erase_run,
  output logic [esv_pkg::DW-1:0]      dq_out,
  output logic                        erasing,
  output logic                        suspended,
  output int                          verify_cnt
);
  logic [DW-1:0] last_q = '0;
  logic [7:0]    sr     = '0;
  logic          sr_mode = 1'b0, got_first = 1'b0, run_q = 1'b0;
  logic          ers = 1'b0, sus = 1'b0;
  int            vcnt = 0;
  realtime       ver_end = 0;
  logic [AW-1:0] w_addr = '0;
  logic [DW-1:0] w_dq   = '0;
  logic          w_sel  = 1'b0;

  assign erasing    = ers;
  assign suspended  = sus;
  assign verify_cnt = vcnt;
  // Released bus shows the inverse of the last word, never a held copy
  assign dq_out = (!oe_n && !ce_n) ? last_q : ~last_q;
  // The host lifts strobe, chip enable and data drive on one edge, so the
  // write is captured while the strobe is low and decoded at its rise
  always @(negedge we_n) begin
    w_addr = addr;
    w_dq   = dq_in;
    w_sel  = !ce_n;
  end

  always @(erase_run or posedge we_n or negedge oe_n or negedge reset_n) begin
    if (!reset_n) begin
      {ers, sus, sr_mode, got_first} = '0;
      sr = '0;
    end else if (erase_run !== run_q) begin
      run_q = erase_run;
      ers = erase_run;
      sus = 1'b0;
    end else if (!oe_n) begin
      if (!ce_n) begin
        if (sr_mode) begin
          last_q = {8'h00, $realtime >= ver_end, 1'b0, sr[5], 4'h0, sr[0]};
        end else if (sus && addr[AW-1:15] == ERASE_SEC) begin
          last_q = 16'h0080;
        end else begin
          last_q = ~addr[DW-1:0];
        end
        sr_mode = 1'b0;
      end
    end else if (w_sel) begin
      case (w_dq)
        CMD_SR_CLEAR: sr[0] = 1'b0;
        CMD_SR_READ:  sr_mode = 1'b1;
        CMD_SUSPEND: if (ers) begin
          ers = 1'b0;
          sus = 1'b1;
        end
        CMD_RESUME: if (sus) begin
          ers = 1'b1;
          sus = 1'b0;
        end
        CMD_VERIFY: if (!ers && !sus && $realtime >= ver_end) begin
          vcnt++;
          ver_end = $realtime + VERIFY_NS;
          sr[5] = w_addr[16];
        end
        PAT_SECOND_W: if (got_first && w_addr == ADDR_SECOND_W) begin
          sr[0] = 1'b1;
        end
        default: ;
      endcase
      got_first = w_dq == PAT_FIRST_W && w_addr == ADDR_FIRST_W;
    end
  end
endmodule
`default_nettype wire

//--- bench/esv_host_tb.sv
/*
  Self-checking bench for esv_host: Wishbone tasks order operations and
  the flash model answers on the far side.
  Assumes esv_pkg, esv_host and esv_flash_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  mismatches++; $display("unexpected %s expected %h seen %h", what, exp, \
  got); end end
module esv_host_tb;
  import esv_pkg::*;
  logic          clk_sys, resetn, we, cyc, stb, ack, erase_run;
  logic [3:0]    adr, sel;
  logic [31:0]   dat, wb_q, r;
  logic [AW-1:0] fl_addr;
  logic [DW-1:0] fl_dq_o, m_dq, dq_bus;
  logic          dq_oe, ce_n, oe_n, we_n, fl_rst_n, m_ers, m_sus;
  int            m_vcnt, mismatches = 0, tests_run = 0;

  assign dq_bus = dq_oe ? fl_dq_o : m_dq;

  esv_host u_esv_host (
    .CLK_SYS(clk_sys), .RESETN(resetn), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(wb_q), .WB_ACK_O(ack), .FL_ADDR(fl_addr),
    .FL_DQ_O(fl_dq_o), .FL_DQ_OE(dq_oe), .FL_DQ_I(dq_bus),
    .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_RESET_N(fl_rst_n));
  esv_flash_model u_esv_flash_model (
    .addr(fl_addr), .dq_in(dq_bus), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .reset_n(fl_rst_n), .erase_run(erase_run), .dq_out(m_dq),
    .erasing(m_ers), .suspended(m_sus), .verify_cnt(m_vcnt));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 40);
    r = wb_q;
    if (ack !== 1'b1) mismatches++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Every operation is followed by polling until the busy flag drops
  task automatic op(input logic [2:0] code);
    int n;
    wb(1'b1, REG_CTRL, {29'h0, code});
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 50);
    if (r[0] !== 1'b0) mismatches++;
  endtask

  task automatic rd(input logic [3:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic setad(input logic [AW-1:0] a);
    wb(1'b1, REG_ADDR, {10'h0, a});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    int n;
    {resetn, cyc, stb, we, erase_run} = '0;
    {adr, dat} = '0;
    sel = 4'hf;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(REG_STATUS);
    `CHK("status", 32'h0, r)
    rd(4'h2);
    `CHK("unmapped", 32'h0, r)
    $display("test reset done");
    op(3'h3);
    rd(REG_STATUS);
    `CHK("cont", 2'b10, r[4:3])
    op(3'h4);
    rd(REG_RDATA);
    `CHK("sr", 8'h81, r[7:0])
    $display("test continuity done");
    erase_run <= 1'b1;
    setad({7'h01, 15'h0005});
    op(3'h0);
    rd(REG_STATUS);
    `CHK("sus", 3'b100, r[2:0])
    `CHK("msus", 1'b1, m_sus)
    op(3'h5);
    rd(REG_RDATA);
    `CHK("ssec", 16'h0080, r[15:0])
    setad(22'h000123);
    op(3'h5);
    rd(REG_RDATA);
    `CHK("arr", 16'hfedc, r[15:0])
    op(3'h2);
    rd(REG_STATUS);
    `CHK("vref", 1'b1, r[1])
    `CHK("vcnt", 0, m_vcnt)
    op(3'h1);
    op(3'h1);
    `CHK("res", 2'b10, {m_ers, m_sus})
    op(3'h0);
    `CHK("guard", 2'b10, {m_ers, m_sus})
    repeat (1000) @(posedge clk_sys);
    op(3'h0);
    `CHK("sus2", 2'b01, {m_ers, m_sus})
    op(3'h1);
    erase_run <= 1'b0;
    @(posedge clk_sys);
    $display("test suspend done");
    for (int i = 0; i < 2; i++) begin
      setad({5'h0, i[0], 16'h0});
      op(3'h2);
      op(3'h4);
      rd(REG_RDATA);
      `CHK("vbusy", 1'b0, r[7])
      n = 0;
      while (r[7] !== 1'b1 && n < 20) begin
        op(3'h4);
        rd(REG_RDATA);
        n++;
      end
      `CHK("vdone", 1'b1, r[7])
      `CHK("verase", i[0], r[5])
      `CHK("vcnt2", i + 1, m_vcnt)
    end
    $display("test verify done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
